// ==== rtl/crf_top.v ====
// receive flag register, acceptance filter and receive data segment registers of a can controller
`timescale 1ns/10ps
`include "crf_consts.vh"
module crf_top
(
    // clock and reset
    input  wire        mclk,
    input  wire        reset_n,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // controller state and error counters
    input  wire        sleep_active,
    input  wire        bus_activity,
    input  wire [7:0]  rx_err_count,
    input  wire [7:0]  tx_err_count,
    input  wire        tx_bus_off,
    // received frame
    input  wire        frame_valid,
    input  wire [31:0] frame_id,
    input  wire [3:0]  frame_dlc,
    input  wire [63:0] frame_data,
    // results
    output reg         frame_accepted,
    output reg         irq
);

    // ------------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------------
    // one 32-bit bank: mask bit 1 means don't care
    function bank_hit;
        input [31:0] code;
        input [31:0] mask;
        input [31:0] id;
        begin
            bank_hit = &(~(code ^ id) | mask);
        end
    endfunction

    // error counter to two-bit bus status
    function [1:0] cnt_status;
        input [7:0] cnt;
        begin
            if (cnt >= `CRF_CNT_ERR)
                cnt_status = 2'h2;
            else if (cnt >= `CRF_CNT_WARN)
                cnt_status = 2'h1;
            else
                cnt_status = 2'h0;
        end
    endfunction

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    reg        init_req_q;       // init request
    reg        init_ack_q;       // init acknowledge
    reg        wake_en_q;        // wake-up enable
    reg        wake_flag_q;      // wake-up flag
    reg        schg_flag_q;      // status change flag
    reg [1:0]  rx_st_q;          // rx bus status
    reg [1:0]  tx_st_q;          // tx bus status
    reg [1:0]  rier_q;           // flag interrupt enables
    // filter banks hold byte 0 in bits 31:24
    reg [31:0] code_lo_q;        // code bytes 0..3
    reg [31:0] code_hi_q;        // code bytes 4..7
    reg [31:0] mask_lo_q;        // mask bytes 0..3
    reg [31:0] mask_hi_q;        // mask bytes 4..7
    reg [31:0] idb_q;            // received identifier bytes
    reg [3:0]  dlc_q;            // received length code
    reg [7:0]  dsr_q [0:7];      // data segment bytes
    reg [3:0]  evt_stat_q;       // sticky event status
    reg [3:0]  evt_mask_q;       // event mask

    // ------------------------------------------------------------------------
    // combinational terms
    // ------------------------------------------------------------------------
    // init mode needs both request and acknowledge
    wire       init_mode = init_req_q & init_ack_q;
    // flag writes need init fully left: both bits low
    wire       flag_wr_ok = ~init_req_q & ~init_ack_q;
    // live bus status from the error counters
    wire [1:0] rx_st_now = cnt_status(rx_err_count);
    // bus-off is reported on the transmit side only
    wire [1:0] tx_st_now = tx_bus_off ? 2'h3 : cnt_status(tx_err_count);
    wire       wake_set = sleep_active & bus_activity & wake_en_q;
    wire       st_diff = (rx_st_now != rx_st_q) | (tx_st_now != tx_st_q);
    // no new change while one is pending or in init
    wire       schg_set = st_diff & ~schg_flag_q & ~init_mode;
    // write strobe aimed at the flag register
    wire       wr_rflg = reg_wr & (reg_addr == `CRF_ADDR_RFLG);
    wire       hit = bank_hit(code_lo_q, mask_lo_q, frame_id) |
                     bank_hit(code_hi_q, mask_hi_q, frame_id);
    // frames are ignored while init mode is active
    wire       accept = frame_valid & hit & ~init_mode;
    wire       reject = frame_valid & ~hit & ~init_mode;
    // event vector in status bit order
    wire [3:0] evt_now = {reject, accept, schg_set, wake_set & ~init_mode};
    // a read of event status clears it
    wire       rd_evt = reg_rd & (reg_addr == `CRF_ADDR_EVT_STAT);

    // ------------------------------------------------------------------------
    // control and init handshake
    // ------------------------------------------------------------------------
    // acknowledge follows request one clock later
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            init_req_q <= 1'b0;
            init_ack_q <= 1'b0;
            wake_en_q  <= 1'b0;
            rier_q     <= 2'h0;
            evt_mask_q <= 4'h0;
        end
        else
        begin
            // acknowledge simply trails the request
            init_ack_q <= init_req_q;
            if (reg_wr && reg_addr == `CRF_ADDR_CTRL0)
            begin
                init_req_q <= reg_wdata[`CRF_CTRL0_INIT_REQUEST];
                wake_en_q  <= reg_wdata[`CRF_CTRL0_WAKE_EN];
            end
            if (reg_wr && reg_addr == `CRF_ADDR_RIER)
                rier_q <= reg_wdata[7:6];
            if (reg_wr && reg_addr == `CRF_ADDR_EVT_MASK)
                evt_mask_q <= reg_wdata[3:0];
        end
    end

    // ------------------------------------------------------------------------
    // receiver flags
    // ------------------------------------------------------------------------
    // set wins over write clear; wake clears only once its cause is gone
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wake_flag_q <= 1'b0;
            schg_flag_q <= 1'b0;
        end
        // flags held reset in init mode
        // cleared as soon as the request is seen, so the
        // flags already read zero in the first cycle in
        // which request and acknowledge are both high
        else if (init_req_q)
        begin
            wake_flag_q <= 1'b0;
            schg_flag_q <= 1'b0;
        end
        else
        begin
            if (wake_set)
                wake_flag_q <= 1'b1;
            // write one clears once wake cause is gone
            else if (wr_rflg && flag_wr_ok && reg_wdata[`CRF_RFLG_WAKE])
                wake_flag_q <= 1'b0;
            if (schg_set)
                schg_flag_q <= 1'b1;
            // writes of zero ignored, ones clear
            else if (wr_rflg && flag_wr_ok && reg_wdata[`CRF_RFLG_SCHG])
                schg_flag_q <= 1'b0;
        end
    end

    // bus status fields
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_st_q <= `CRF_RST_ST;
            tx_st_q <= `CRF_RST_ST;
        end
        // untouched by init; frozen while flag set
        else if (schg_set)
        begin
            rx_st_q <= rx_st_now;
            tx_st_q <= tx_st_now;
        end
    end

    // ------------------------------------------------------------------------
    // acceptance code and mask registers
    // ------------------------------------------------------------------------
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            code_lo_q <= 32'h0000_0000;
            code_hi_q <= 32'h0000_0000;
            mask_lo_q <= 32'h0000_0000;
            mask_hi_q <= 32'h0000_0000;
        end
        else if (reg_wr && init_mode)
        begin
            // mask bits stored as don't care selects
            if (reg_addr[7:2] == `CRF_ADDR_CODE0 >> 2)
                code_lo_q[8*(3-reg_addr[1:0]) +: 8] <= reg_wdata;
            else if (reg_addr[7:2] == `CRF_ADDR_MASK0 >> 2)
                mask_lo_q[8*(3-reg_addr[1:0]) +: 8] <= reg_wdata;
            else if (reg_addr[7:2] == `CRF_ADDR_CODE4 >> 2)
                code_hi_q[8*(3-reg_addr[1:0]) +: 8] <= reg_wdata;
            else if (reg_addr[7:2] == `CRF_ADDR_MASK4 >> 2)
                mask_hi_q[8*(3-reg_addr[1:0]) +: 8] <= reg_wdata;
        end
    end

    // ------------------------------------------------------------------------
    // receive buffer: identifier and length
    // ------------------------------------------------------------------------
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            idb_q <= 32'h0000_0000;
            dlc_q <= `CRF_RST_DLC;
        end
        else if (accept)
        begin
            idb_q <= frame_id;
            dlc_q <= frame_dlc;
        end
        // software may also fill the buffer by hand
        else if (reg_wr && reg_addr[7:2] == `CRF_ADDR_IDB0 >> 2)
            idb_q[8*(3-reg_addr[1:0]) +: 8] <= reg_wdata;
        else if (reg_wr && reg_addr == `CRF_ADDR_DLC)
            dlc_q <= reg_wdata[3:0];
    end

    // data segment bytes, byte 0 in frame_data[63:56]
    genvar gi;
    generate
        for (gi = 0; gi < `CRF_NUM_BYTES; gi = gi + 1)
        begin : g_dsr
            always @(posedge mclk or negedge reset_n)
            begin
                if (!reset_n)
                    dsr_q[gi] <= `CRF_RST_BYTE;
                else if (accept)
                    dsr_q[gi] <= (gi < frame_dlc) ? frame_data[63-8*gi -: 8] : `CRF_RST_BYTE;
                else if (reg_wr && reg_addr == `CRF_ADDR_DATA_SEGMENT_0 + gi)
                    dsr_q[gi] <= reg_wdata;
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // event status, interrupt and result outputs
    // ------------------------------------------------------------------------
    // sticky events, cleared by read; new event wins
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            evt_stat_q     <= 4'h0;
            frame_accepted <= 1'b0;
            irq            <= 1'b0;
        end
        else
        begin
            evt_stat_q     <= (rd_evt ? 4'h0 : evt_stat_q) | evt_now;
            // accept pulse follows the frame by one clock
            frame_accepted <= accept;
            // enabled flags and unmasked events raise irq
            irq <= |({wake_flag_q, schg_flag_q} & rier_q) | |(evt_stat_q & evt_mask_q);
        end
    end

    // ------------------------------------------------------------------------
    // read data, one cycle after strobe
    // ------------------------------------------------------------------------
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= `CRF_RST_BYTE;
        else if (!reg_rd)
            reg_rdata <= `CRF_RST_BYTE;
        // control: request and wake enable
        else if (reg_addr == `CRF_ADDR_CTRL0)
            reg_rdata <= {5'h00, wake_en_q, 1'b0, init_req_q};
        else if (reg_addr == `CRF_ADDR_CTRL1)
            reg_rdata <= {7'h00, init_ack_q};
        // flags: wake, change, rx and tx status
        else if (reg_addr == `CRF_ADDR_RFLG)
            reg_rdata <= {wake_flag_q, schg_flag_q, rx_st_q, tx_st_q, 2'h0};
        else if (reg_addr == `CRF_ADDR_RIER)
            reg_rdata <= {rier_q, 6'h00};
        else if (reg_addr[7:2] == `CRF_ADDR_CODE0 >> 2)
            reg_rdata <= code_lo_q[8*(3-reg_addr[1:0]) +: 8];
        else if (reg_addr[7:2] == `CRF_ADDR_MASK0 >> 2)
            reg_rdata <= mask_lo_q[8*(3-reg_addr[1:0]) +: 8];
        else if (reg_addr[7:2] == `CRF_ADDR_CODE4 >> 2)
            reg_rdata <= code_hi_q[8*(3-reg_addr[1:0]) +: 8];
        else if (reg_addr[7:2] == `CRF_ADDR_MASK4 >> 2)
            reg_rdata <= mask_hi_q[8*(3-reg_addr[1:0]) +: 8];
        else if (reg_addr[7:2] == `CRF_ADDR_IDB0 >> 2)
            reg_rdata <= idb_q[8*(3-reg_addr[1:0]) +: 8];
        // data bytes 0..3 at 0x24..0x27
        else if (reg_addr[7:3] == `CRF_ADDR_DATA_SEGMENT_0 >> 3 && reg_addr[2])
            reg_rdata <= dsr_q[reg_addr[2:0] - 3'h4];
        // data bytes 4..7 at 0x28..0x2b
        else if (reg_addr[7:3] == (`CRF_ADDR_DATA_SEGMENT_0 >> 3) + 5'h01 && !reg_addr[2])
            reg_rdata <= dsr_q[reg_addr[2:0] + 3'h4];
        else if (reg_addr == `CRF_ADDR_DLC)
            reg_rdata <= {4'h0, dlc_q};
        else if (reg_addr == `CRF_ADDR_EVT_STAT)
            reg_rdata <= {4'h0, evt_stat_q};
        else if (reg_addr == `CRF_ADDR_EVT_MASK)
            reg_rdata <= {4'h0, evt_mask_q};
        // unmapped reads return zero
        else
            reg_rdata <= `CRF_RST_BYTE;
    end

endmodule // crf_top

// ==== common/crf_consts.vh ====
// register offsets, field positions, reset values and status thresholds of the receive flag block
`ifndef CRF_CONSTS_VH
`define CRF_CONSTS_VH

// ----------------------------------------------------------------------------
// register offsets (8-bit byte addresses)
// ----------------------------------------------------------------------------
`define CRF_ADDR_CTRL0       8'h00
`define CRF_ADDR_CTRL1       8'h01
`define CRF_ADDR_RFLG        8'h04
`define CRF_ADDR_RIER        8'h05
`define CRF_ADDR_CODE0       8'h10
`define CRF_ADDR_MASK0       8'h14
`define CRF_ADDR_MASK3       8'h17
`define CRF_ADDR_CODE4       8'h18
`define CRF_ADDR_CODE7       8'h1b
`define CRF_ADDR_MASK4       8'h1c
`define CRF_ADDR_IDB0        8'h20
`define CRF_ADDR_DATA_SEGMENT_0        8'h24
`define CRF_ADDR_DLC         8'h2c
`define CRF_ADDR_EVT_STAT    8'h30
`define CRF_ADDR_EVT_MASK    8'h31

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CRF_CTRL0_INIT_REQUEST     0
`define CRF_CTRL0_WAKE_EN    2
`define CRF_CTRL1_INIT_ACKNOWLEDGE     0
`define CRF_RFLG_WAKE        7
`define CRF_RFLG_SCHG        6
`define CRF_RFLG_RXST_HI     5
`define CRF_RFLG_RXST_LO     4
`define CRF_RFLG_TXST_HI     3
`define CRF_RFLG_TXST_LO     2
`define CRF_EVT_WAKE         0
`define CRF_EVT_SCHG         1
`define CRF_EVT_ACCEPT       2
`define CRF_EVT_REJECT       3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CRF_RST_BYTE         8'h00
`define CRF_RST_ST           2'h0
`define CRF_RST_DLC          4'h0

// ----------------------------------------------------------------------------
// error counter thresholds for bus status, and the data segment byte count
// ----------------------------------------------------------------------------
`define CRF_CNT_WARN         8'h60
`define CRF_CNT_ERR          8'h80
`define CRF_NUM_BYTES        8

`endif

// ==== testbench/crf_props.sv ====
// assertions on the receive flag block ports
`timescale 1ns/10ps
`include "crf_consts.vh"
module crf_props
(
    // clock and reset
    input wire       mclk,
    input wire       reset_n,
    // register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    // frame and results
    input wire       frame_valid,
    input wire       frame_accepted,
    input wire       irq
);
    reg       req_q;  // init request mirror
    reg       ack_q;  // init acknowledge mirror
    reg [1:0] rier_q; // flag enable mirror
    reg [7:0] emsk_q; // event mask mirror
    wire      init_w; // init mode active
    assign init_w = req_q & ack_q;
    // ----
    // mirror of control writes
    // ----
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            req_q <= 1'b0;
            ack_q <= 1'b0;
            rier_q <= 2'h0;
            emsk_q <= 8'h00;
        end
        else
        begin
            if (reg_wr && reg_addr == `CRF_ADDR_CTRL0)
                req_q <= reg_wdata[`CRF_CTRL0_INIT_REQUEST];
            if (reg_wr && reg_addr == `CRF_ADDR_RIER)
                rier_q <= reg_wdata[7:6];
            if (reg_wr && reg_addr == `CRF_ADDR_EVT_MASK)
                emsk_q <= reg_wdata;
            ack_q <= req_q;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    a_accept_cause: assert property (!frame_valid |=> !frame_accepted)
        else $error("accept without frame");
    a_init_no_accept: assert property (frame_valid && init_w |=> !frame_accepted)
        else $error("frame accepted in init");
    a_flags_low_zero: assert property (reg_rd && reg_addr == `CRF_ADDR_RFLG |=> reg_rdata[1:0] == 2'h0)
        else $error("flag low bits set");
    a_init_flags_reset: assert property (reg_rd && reg_addr == `CRF_ADDR_RFLG && init_w
        |=> reg_rdata[7:6] == 2'h0)
        else $error("flags not reset in init");
    a_ack_readback: assert property (reg_rd && reg_addr == `CRF_ADDR_CTRL1 |=> reg_rdata[0] == $past(ack_q))
        else $error("ack bit wrong");
    a_irq_masked: assert property (rier_q == 2'h0 && emsk_q == 8'h00 |=> !irq)
        else $error("irq while masked");
    a_dlc_width: assert property (reg_rd && reg_addr == `CRF_ADDR_DLC |=> reg_rdata[7:4] == 4'h0)
        else $error("length code too wide");
endmodule // crf_props

bind crf_top crf_props u_crf_props (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_valid(frame_valid), .frame_accepted(frame_accepted), .irq(irq));

// ==== testbench/crf_can_node.sv ====
// model of the far can node delivering frames and bus activity
`timescale 1ns/10ps
module crf_can_node
(
    // clock
    input wire         mclk,
    // frame side
    output reg         frame_valid,
    output reg  [31:0] frame_id,
    output reg  [3:0]  frame_dlc,
    output reg  [63:0] frame_data,
    output reg         bus_activity
);
    // idle lines at start
    initial
    begin
        frame_valid = 1'b0;
        frame_id = 32'h00000000;
        frame_dlc = 4'h0;
        frame_data = 64'h0;
        bus_activity = 1'b0;
    end
    // one frame for one cycle, lines scrambled after
    task send(input [31:0] id, input [3:0] dlc, input [63:0] d);
    begin
        @(posedge mclk);
        frame_valid <= 1'b1;
        frame_id <= id;
        frame_dlc <= dlc;
        frame_data <= d;
        @(posedge mclk);
        frame_valid <= 1'b0;
        frame_id <= ~id;
        frame_dlc <= ~dlc;
        frame_data <= ~d;
        // return past the edge so callers see the registered answer
        #1;
    end
    endtask
    // bus activity level
    task activity(input v);
    begin
        @(posedge mclk);
        bus_activity <= v;
    end
    endtask
endmodule // crf_can_node

// ==== testbench/testbench.sv ====
// self-checking bench of the receive flag block
`timescale 1ns/10ps
`include "crf_consts.vh"
module testbench;
    reg         mclk, reset_n, reg_wr, reg_rd, sleep_active, tx_bus_off;
    reg  [7:0]  reg_addr, reg_wdata, rx_err_count, tx_err_count;
    wire [7:0]  reg_rdata;
    wire        frame_valid, bus_activity, frame_accepted, irq;
    wire [31:0] frame_id;
    wire [3:0]  frame_dlc;
    wire [63:0] frame_data;
    reg  [31:0] c0, m0, m4; // filter set-up
    reg  [63:0] fd;         // frame payload
    integer     fails, comparisons, cycles, i;
    crf_top u_crf_top (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_active(sleep_active),
        .bus_activity(bus_activity), .rx_err_count(rx_err_count), .tx_err_count(tx_err_count),
        .tx_bus_off(tx_bus_off), .frame_valid(frame_valid), .frame_id(frame_id), .frame_dlc(frame_dlc),
        .frame_data(frame_data), .frame_accepted(frame_accepted), .irq(irq));
    crf_can_node u_crf_can_node (.mclk(mclk), .frame_valid(frame_valid), .frame_id(frame_id),
        .frame_dlc(frame_dlc), .frame_data(frame_data), .bus_activity(bus_activity));
    // clock and hang guard
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cycles = cycles + 1;
        if (cycles == 3000)
        begin
            fails = fails + 1;
            $display("[FAIL] %0t timeout", $time);
            end_sim;
        end
    end
    // ----
    // access and compare tasks
    // ----
    task end_sim;
    begin
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
    begin
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task wr(input [7:0] a, input [7:0] d);
    begin
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    end
    endtask
    task rdc(input [7:0] a, input [7:0] e);
    begin
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    end
    endtask
    // ----
    // main sequence
    // ----
    initial
    begin
        {reset_n, reg_wr, reg_rd, sleep_active, tx_bus_off} = 5'h0;
        {reg_addr, reg_wdata, rx_err_count, tx_err_count} = 32'h0;
        {fails, comparisons, cycles} = 0;
        c0 = 32'h123456aa;
        m0 = 32'h000700ff;
        m4 = 32'h00070007;
        fd = 64'h1122334455667788;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        for (i = 0; i < 8'h40; i = i + 1)
            rdc(i[7:0], 8'h00);
        wr(`CRF_ADDR_CODE0, 8'ha5);
        rdc(`CRF_ADDR_CODE0, 8'h00);
        wr(`CRF_ADDR_CTRL0, 8'h01);
        rdc(`CRF_ADDR_CTRL1, 8'h01);
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(`CRF_ADDR_CODE0 + i[7:0], c0[31-8*i -: 8]);
            wr(`CRF_ADDR_MASK0 + i[7:0], m0[31-8*i -: 8]);
            wr(`CRF_ADDR_CODE4 + i[7:0], 8'hff);
            wr(`CRF_ADDR_MASK4 + i[7:0], m4[31-8*i -: 8]);
            rdc(`CRF_ADDR_MASK0 + i[7:0], m0[31-8*i -: 8]);
        end
        wr(`CRF_ADDR_CTRL0, 8'h00);
        wr(`CRF_ADDR_EVT_MASK, 8'h04);
        u_crf_can_node.send(32'h123556ab, 4'h3, fd);
        chk({7'h00, frame_accepted}, 8'h01);
        for (i = 0; i < 8; i = i + 1)
            rdc(`CRF_ADDR_DATA_SEGMENT_0 + i[7:0], (i < 3) ? fd[63-8*i -: 8] : 8'h00);
        rdc(`CRF_ADDR_DLC, 8'h03);
        rdc(`CRF_ADDR_IDB0 + 8'h01, 8'h35);
        u_crf_can_node.send(32'h023456aa, 4'h8, fd);
        chk({7'h00, frame_accepted}, 8'h00);
        u_crf_can_node.send(32'hfff8ffff, 4'h8, fd);
        chk({7'h00, frame_accepted}, 8'h01);
        rdc(`CRF_ADDR_DATA_SEGMENT_0 + 8'h07, 8'h88);
        chk({7'h00, irq}, 8'h01);
        rdc(`CRF_ADDR_EVT_STAT, 8'h0c);
        repeat (2) @(posedge mclk);
        chk({7'h00, irq}, 8'h00);
        wr(`CRF_ADDR_RIER, 8'h40);
        rx_err_count <= 8'h60;
        rdc(`CRF_ADDR_RFLG, 8'h50);
        chk({7'h00, irq}, 8'h01);
        @(posedge mclk);
        rx_err_count <= 8'h80;
        rdc(`CRF_ADDR_RFLG, 8'h50);
        wr(`CRF_ADDR_RFLG, 8'h40);
        rdc(`CRF_ADDR_RFLG, 8'h60);
        wr(`CRF_ADDR_RFLG, 8'h40);
        rdc(`CRF_ADDR_RFLG, 8'h20);
        chk({7'h00, irq}, 8'h00);
        @(posedge mclk);
        tx_bus_off <= 1'b1;
        rdc(`CRF_ADDR_RFLG, 8'h6c);
        wr(`CRF_ADDR_RFLG, 8'h7c);
        rdc(`CRF_ADDR_RFLG, 8'h2c);
        @(posedge mclk);
        sleep_active <= 1'b1;
        u_crf_can_node.activity(1'b1);
        rdc(`CRF_ADDR_RFLG, 8'h2c);
        wr(`CRF_ADDR_CTRL0, 8'h04);
        rdc(`CRF_ADDR_RFLG, 8'hac);
        wr(`CRF_ADDR_RFLG, 8'h80);
        rdc(`CRF_ADDR_RFLG, 8'hac);
        u_crf_can_node.activity(1'b0);
        wr(`CRF_ADDR_RFLG, 8'h80);
        rdc(`CRF_ADDR_RFLG, 8'h2c);
        u_crf_can_node.activity(1'b1);
        u_crf_can_node.activity(1'b0);
        wr(`CRF_ADDR_CTRL0, 8'h01);
        rdc(`CRF_ADDR_RFLG, 8'h2c);
        u_crf_can_node.send(c0, 4'h1, fd);
        chk({7'h00, frame_accepted}, 8'h00);
        wr(`CRF_ADDR_CTRL0, 8'h00);
        rdc(`CRF_ADDR_RFLG, 8'h2c);
        end_sim;
    end
endmodule // testbench
